// File: verilog/pmc_pkg.sv
// Constants shared by the power-management capability register bank
package pmc_pkg;

  // Register byte offsets on the configuration port
  localparam logic [7:0] PMC_CAP_ADDR = 8'ha2;
  localparam logic [7:0] PMC_CTL_ADDR = 8'ha4;

  // Capability register reset value and field positions
  localparam logic [15:0] PMC_CAP_RESET = 16'hfe21;
  localparam int PMC_CAP_COLD_BIT = 15;
  localparam int PMC_CAP_MASK_HI = 14;
  localparam int PMC_CAP_MASK_LO = 11;
  localparam int PMC_CAP_D2_BIT = 10;
  localparam int PMC_CAP_D1_BIT = 9;
  localparam int PMC_CAP_RSVD_HI = 8;
  localparam int PMC_CAP_RSVD_LO = 6;
  localparam int PMC_CAP_INIT_BIT = 5;
  localparam int PMC_CAP_AUX_BIT = 4;
  localparam int PMC_CAP_CLK_BIT = 3;
  localparam int PMC_CAP_VER_HI = 2;

  // Fixed field values of the capability register
  localparam logic [3:0] PMC_CAP_MASK_FIXED = 4'hf;
  localparam logic [2:0] PMC_CAP_RSVD_VAL = 3'h0;
  localparam logic PMC_CAP_D2_VAL = 1'b1;
  localparam logic PMC_CAP_D1_VAL = 1'b1;
  localparam logic PMC_CAP_INIT_VAL = 1'b1;
  localparam logic PMC_CAP_AUX_VAL = 1'b0;
  localparam logic PMC_CAP_CLK_VAL = 1'b0;
  localparam logic [2:0] PMC_CAP_VER_VAL = 3'h1;
  localparam logic PMC_CAP_COLD_RESET = 1'b1;

  // Control and status register field positions and reset values
  localparam int PMC_CTL_STATUS_BIT = 15;
  localparam int PMC_CTL_ENABLE_BIT = 8;
  localparam int PMC_CTL_STATE_HI = 1;
  localparam logic PMC_CTL_ENABLE_RESET = 1'b0;
  localparam logic PMC_CTL_STATUS_RESET = 1'b0;

  // Number of wake-capability mask bits
  localparam int PMC_MASK_WIDTH = 5;

  // Power states as held in the control register
  typedef enum logic [1:0] {
    PMC_D0 = 2'b00,
    PMC_D1 = 2'b01,
    PMC_D2 = 2'b10,
    PMC_D3HOT = 2'b11
  } pmc_state_e;

endpackage : pmc_pkg

// File: verilog/pmc_sticky_flag.sv
// Sticky status flag where a set beats a clear in the same cycle
`timescale 1ns/10ps
module pmc_sticky_flag
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic setPulse,
  input wire logic clearPulse,
  output logic flag_q
);

  // Set wins so an event during a clear is never lost
  always_ff @(posedge clk)
  begin
    if (reset)
      flag_q <= PMC_CTL_STATUS_RESET;
    else if (setPulse)
      flag_q <= 1'b1;
    else if (clearPulse)
      flag_q <= 1'b0;
  end

endmodule : pmc_sticky_flag

// File: verilog/pmc_wake_select.sv
// Picks the wake-capability mask bit for the present power state
`timescale 1ns/10ps
module pmc_wake_select
  import pmc_pkg::*;
(
  input wire logic [PMC_MASK_WIDTH-1:0] wakeStateMask,
  input wire pmc_state_e powerState,
  input wire logic coldState,
  output logic wakeAllowed
);

  // Mask order: bit 0 is D0 up to bit 4 for the cold state
  always_comb
  begin
    wakeAllowed = 1'b0;
    if (coldState)
      wakeAllowed = wakeStateMask[4];
    else
      case (powerState)
        PMC_D0: wakeAllowed = wakeStateMask[0];
        PMC_D1: wakeAllowed = wakeStateMask[1];
        PMC_D2: wakeAllowed = wakeStateMask[2];
        PMC_D3HOT: wakeAllowed = wakeStateMask[3];
        default: wakeAllowed = 1'b0;
      endcase
  end

endmodule : pmc_wake_select

// File: verilog/pmc_capabilities.sv
// Power-management capability register bank with wake request gating
`timescale 1ns/10ps

// Summary of operation
// - Capability register at A2h resets FE21h
// - Bit 15 writable, resets 1, cold wake
// - Bits 14-11 read-only ones, hot to D0
// - Mask bit zero blocks wake in state
// - Bit 10 reads one, D2 supported
// - Bit 9 reads one, D1 supported
// - Bits 8-6 reserved, read zero
// - Bit 5 reads one, needs initialization
// - Bit 4 aux supply flag, read-only
// - Bit 3 reads zero, no clock needed
// - Bits 2-0 read version 001b
// - Wake request only while enable set
module pmc_capabilities
  import pmc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic [15:0] writeData,
  input wire logic writeStrobe,
  input wire logic readStrobe,
  output logic [15:0] readData_q,
  input wire logic wakeEvent,
  input wire logic coldState,
  output logic wakeRequest_q,
  output logic [1:0] powerState_q
);

  ////////////////////////////////////////////////////////////////////
  // Address decode

  logic capHit;
  logic ctlHit;
  logic capWrite;
  logic ctlWrite;

  // Exact byte-offset match; anything else is unmapped
  always_comb
  begin
    capHit = 1'b0;
    ctlHit = 1'b0;
    if (address == PMC_CAP_ADDR)
      capHit = 1'b1;
    else if (address == PMC_CTL_ADDR)
      ctlHit = 1'b1;
  end

  assign capWrite = writeStrobe && capHit;
  assign ctlWrite = writeStrobe && ctlHit;

  ////////////////////////////////////////////////////////////////////
  // Capability register

  logic coldWake_q;
  logic [14:0] capFixed;
  logic [15:0] capValue;

  // Only the cold-state wake bit is storage; firmware may withdraw it
  always_ff @(posedge clk)
  begin
    if (reset)
      coldWake_q <= PMC_CAP_COLD_RESET;
    else if (capWrite)
      coldWake_q <= writeData[PMC_CAP_COLD_BIT];
  end

  // Hard-wired lower fields; write data never reaches them
  assign capFixed = {
    PMC_CAP_MASK_FIXED,
    PMC_CAP_D2_VAL,
    PMC_CAP_D1_VAL,
    PMC_CAP_RSVD_VAL,
    PMC_CAP_INIT_VAL,
    PMC_CAP_AUX_VAL,
    PMC_CAP_CLK_VAL,
    PMC_CAP_VER_VAL
  };

  // Whole register as seen by software
  assign capValue = {coldWake_q, capFixed};

  ////////////////////////////////////////////////////////////////////
  // Control and status register

  logic wakeEnable_q;
  logic wakeStatus_q;
  logic wakeAllowed;
  logic [15:0] ctlValue;

  // Enable bit for driving the wake request
  always_ff @(posedge clk)
  begin
    if (reset)
      wakeEnable_q <= PMC_CTL_ENABLE_RESET;
    else if (ctlWrite)
      wakeEnable_q <= writeData[PMC_CTL_ENABLE_BIT];
  end

  // Power state field steers which mask bit applies
  always_ff @(posedge clk)
  begin
    if (reset)
      powerState_q <= PMC_D0;
    else if (ctlWrite)
      powerState_q <= writeData[PMC_CTL_STATE_HI:0];
  end

  // Mask of states from which wake may be raised
  pmc_wake_select u_select (
    .wakeStateMask({coldWake_q, capFixed[PMC_CAP_MASK_HI:PMC_CAP_MASK_LO]}),
    .powerState(pmc_state_e'(powerState_q)),
    .coldState(coldState),
    .wakeAllowed(wakeAllowed)
  );

  // Status sets on an allowed event regardless of enable
  pmc_sticky_flag u_status (
    .clk(clk),
    .reset(reset),
    .setPulse(wakeEvent && wakeAllowed),
    .clearPulse(ctlWrite && writeData[PMC_CTL_STATUS_BIT]),
    .flag_q(wakeStatus_q)
  );

  // Read view: status, enable, state, rest zero
  always_comb
  begin
    ctlValue = 16'h0000;
    ctlValue[PMC_CTL_STATUS_BIT] = wakeStatus_q;
    ctlValue[PMC_CTL_ENABLE_BIT] = wakeEnable_q;
    ctlValue[PMC_CTL_STATE_HI:0] = powerState_q;
  end

  ////////////////////////////////////////////////////////////////////
  // Wake request output

  // Registered so the pin never glitches on decode changes
  always_ff @(posedge clk)
  begin
    if (reset)
      wakeRequest_q <= 1'b0;
    else
      wakeRequest_q <= wakeStatus_q && wakeEnable_q && wakeAllowed;
  end

  ////////////////////////////////////////////////////////////////////
  // Read data

  // Data stand only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk)
  begin
    if (reset)
      readData_q <= 16'h0000;
    else if (readStrobe && capHit)
      readData_q <= capValue;
    else if (readStrobe && ctlHit)
      readData_q <= ctlValue;
    else
      readData_q <= 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions

  capValue_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q == {$past(coldWake_q), 15'h7e21})
    else $error("capability read value wrong");

  resetValue_a: assert property (
    @(posedge clk)
    $fell(reset) && !writeStrobe |-> capValue == PMC_CAP_RESET)
    else $error("capability reset value wrong");

  coldWrite_a: assert property (
    @(posedge clk) disable iff (reset)
    capWrite |=> coldWake_q == $past(writeData[PMC_CAP_COLD_BIT]))
    else $error("cold wake bit not written");

  maskBits_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q[14:11] == 4'hf)
    else $error("wake mask bits not all one");

  maskBlock_a: assert property (
    @(posedge clk) disable iff (reset)
    coldState && !coldWake_q && !wakeStatus_q ##1 coldState && !coldWake_q
    |=> !wakeRequest_q)
    else $error("wake raised from masked state");

  stateTwo_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q[10])
    else $error("state two flag not one");

  stateOne_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q[9])
    else $error("state one flag not one");

  reserved_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q[8:6] == 3'h0)
    else $error("reserved bits not zero");

  initFlag_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q[5])
    else $error("initialization flag not one");

  auxFlag_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q[4] == 1'b0)
    else $error("aux supply flag changed");

  wakeClock_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> !readData_q[3])
    else $error("wake clock flag not zero");

  version_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && capHit |=> readData_q[2:0] == 3'b001)
    else $error("version field wrong");

  wakeGate_a: assert property (
    @(posedge clk) disable iff (reset)
    !wakeEnable_q |=> !wakeRequest_q)
    else $error("wake request without enable");

  wakeRaise_a: assert property (
    @(posedge clk) disable iff (reset)
    wakeStatus_q && wakeEnable_q && wakeAllowed |=> wakeRequest_q)
    else $error("wake request not raised");

  fixedHold_a: assert property (
    @(posedge clk) disable iff (reset)
    capWrite ##1 (readStrobe && capHit) |=> readData_q[14:0] == 15'h7e21)
    else $error("read-only bits changed by write");

  setWins_a: assert property (
    @(posedge clk) disable iff (reset)
    wakeEvent && wakeAllowed && ctlWrite |=> wakeStatus_q)
    else $error("wake event lost during clear");

  readOnce_a: assert property (
    @(posedge clk) disable iff (reset)
    !readStrobe |=> readData_q == 16'h0000)
    else $error("read data outside its cycle");

  ////////////////////////////////////////////////////////////////////
  // Read decode and reset checks

  ctlRead_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && ctlHit |=> readData_q == {$past(wakeStatus_q), 6'h00,
      $past(wakeEnable_q), 6'h00, $past(powerState_q)})
    else $error("control read value wrong");

  unmappedRead_a: assert property (
    @(posedge clk) disable iff (reset)
    readStrobe && !capHit && !ctlHit |=> readData_q == 16'h0000)
    else $error("unmapped read not zero");

  resetOut_a: assert property (
    @(posedge clk)
    reset |=> readData_q == 16'h0000 && !wakeRequest_q && powerState_q == 2'b00)
    else $error("outputs not at reset values");

  resetState_a: assert property (
    @(posedge clk)
    reset |=> coldWake_q && !wakeEnable_q && !wakeStatus_q)
    else $error("register state not at reset values");

  ////////////////////////////////////////////////////////////////////
  // Register storage checks

  coldHold_a: assert property (
    @(posedge clk) disable iff (reset)
    !capWrite |=> $stable(coldWake_q))
    else $error("cold wake bit changed without write");

  enableWrite_a: assert property (
    @(posedge clk) disable iff (reset)
    ctlWrite |=> wakeEnable_q == $past(writeData[PMC_CTL_ENABLE_BIT]))
    else $error("enable bit not written");

  enableHold_a: assert property (
    @(posedge clk) disable iff (reset)
    !ctlWrite |=> $stable(wakeEnable_q))
    else $error("enable bit changed without write");

  stateWrite_a: assert property (
    @(posedge clk) disable iff (reset)
    ctlWrite |=> powerState_q == $past(writeData[PMC_CTL_STATE_HI:0]))
    else $error("power state not written");

  stateHold_a: assert property (
    @(posedge clk) disable iff (reset)
    !ctlWrite |=> $stable(powerState_q))
    else $error("power state changed without write");

  writeIgnore_a: assert property (
    @(posedge clk) disable iff (reset)
    writeStrobe && !capHit && !ctlHit |=>
      $stable(coldWake_q) && $stable(wakeEnable_q) && $stable(powerState_q))
    else $error("unmapped write changed a register");

  ////////////////////////////////////////////////////////////////////
  // Status and wake checks

  coldMask_a: assert property (
    @(posedge clk) disable iff (reset)
    coldState |-> wakeAllowed == coldWake_q)
    else $error("cold state mask bit not applied");

  hotMask_a: assert property (
    @(posedge clk) disable iff (reset)
    !coldState |-> wakeAllowed)
    else $error("wake blocked in a supported state");

  statusSet_a: assert property (
    @(posedge clk) disable iff (reset)
    wakeEvent && wakeAllowed |=> wakeStatus_q)
    else $error("allowed wake event not latched");

  statusBlock_a: assert property (
    @(posedge clk) disable iff (reset)
    !wakeStatus_q && !(wakeEvent && wakeAllowed) |=> !wakeStatus_q)
    else $error("status set without allowed event");

  statusKeep_a: assert property (
    @(posedge clk) disable iff (reset)
    wakeStatus_q && !(ctlWrite && writeData[PMC_CTL_STATUS_BIT]) |=> wakeStatus_q)
    else $error("status lost without clear");

  statusClear_a: assert property (
    @(posedge clk) disable iff (reset)
    ctlWrite && writeData[PMC_CTL_STATUS_BIT] && !(wakeEvent && wakeAllowed)
    |=> !wakeStatus_q)
    else $error("status not cleared by write");

  requestDrop_a: assert property (
    @(posedge clk) disable iff (reset)
    !wakeStatus_q |=> !wakeRequest_q)
    else $error("wake request without status");

endmodule : pmc_capabilities

// File: bench/tb_top.sv
// Self-checking bench for the power-management capability register bank
`timescale 1ns/10ps
module tb_top
  import pmc_pkg::*;
;
  typedef struct {logic [7:0] a; logic [15:0] d; logic [15:0] e;} pmc_row_s;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] address = 8'h00;
  logic [15:0] writeData = 16'h0000;
  logic writeStrobe = 1'b0;
  logic readStrobe = 1'b0;
  logic wakeEvent = 1'b0;
  logic coldState = 1'b0;
  logic [15:0] readData_q;
  logic wakeRequest_q;
  logic [1:0] powerState_q;
  logic [15:0] v;
  int failures = 0;
  int checked = 0;
  // Write to the capability register, then read it back; last row hits an unmapped place
  pmc_row_s rows [5] = '{
    '{8'ha2, 16'h0000, 16'h7e21},
    '{8'ha2, 16'hffff, 16'hfe21},
    '{8'ha2, 16'h01de, 16'h7e21},
    '{8'ha2, 16'h8000, 16'hfe21},
    '{8'h10, 16'h0000, 16'hfe21}};

`define CHK(n, e, a) \
  begin checked++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", n, e, a); end end

  // Free-running 100 MHz clock
  always #5 clk = ~clk;

  pmc_capabilities i_dut (
    .clk(clk),
    .reset(reset),
    .address(address),
    .writeData(writeData),
    .writeStrobe(writeStrobe),
    .readStrobe(readStrobe),
    .readData_q(readData_q),
    .wakeEvent(wakeEvent),
    .coldState(coldState),
    .wakeRequest_q(wakeRequest_q),
    .powerState_q(powerState_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Bus tasks start on an edge, so no strobe is assigned twice in one step
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    address <= a;
    writeData <= d;
    writeStrobe <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    address <= a;
    readStrobe <= 1'b1;
    @(posedge clk);
    readStrobe <= 1'b0;
    #1 d = readData_q;
  endtask : rd

  // One-cycle wake event, then settle time well past the request latency
  task automatic pulse();
    @(posedge clk);
    wakeEvent <= 1'b1;
    @(posedge clk);
    wakeEvent <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask : pulse

  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: whole run is about 130 cycles, so this is generous
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'ha2, v);
    `CHK("capReset", PMC_CAP_RESET, v)
    @(posedge clk);
    #1 `CHK("readIdle", 16'h0000, readData_q)
    rd(8'ha4, v);
    `CHK("ctlReset", 16'h0000, v)
    $display("test reset done");
    for (int i = 0; i < 5; i++)
    begin
      wr(rows[i].a, rows[i].d);
      rd(8'ha2, v);
      `CHK("capRow", rows[i].e, v)
    end
    rd(8'h10, v);
    `CHK("unmapped", 16'h0000, v)
    $display("test table done");
    // Every power state has its mask bit set, so each must raise the request
    for (int s = 0; s < 4; s++)
    begin
      wr(8'ha4, 16'h0100 | 16'(s));
      pulse();
      `CHK("stateField", 2'(s), powerState_q)
      `CHK("wakeState", 1'b1, wakeRequest_q)
      wr(8'ha4, 16'h8100 | 16'(s));
      repeat (3) @(posedge clk);
      #1 `CHK("wakeClear", 1'b0, wakeRequest_q)
    end
    $display("test states done");
    // Enable off: status latches but the request stays down until enabled
    wr(8'ha4, 16'h0000);
    pulse();
    `CHK("wakeGated", 1'b0, wakeRequest_q)
    rd(8'ha4, v);
    `CHK("statusSet", 16'h8000, v)
    wr(8'ha4, 16'h0100);
    repeat (3) @(posedge clk);
    #1 `CHK("wakeEnabled", 1'b1, wakeRequest_q)
    wr(8'ha4, 16'h8100);
    $display("test enable done");
    // Firmware withdraws cold wake support, then restores it
    wr(8'ha2, 16'h0000);
    coldState <= 1'b1;
    pulse();
    `CHK("coldMasked", 1'b0, wakeRequest_q)
    rd(8'ha4, v);
    `CHK("coldStatus", 16'h0100, v)
    wr(8'ha2, 16'h8000);
    pulse();
    `CHK("coldWake", 1'b1, wakeRequest_q)
    // Clear and a fresh allowed event in one cycle: the event must win
    @(posedge clk);
    address <= 8'ha4;
    writeData <= 16'h8100;
    writeStrobe <= 1'b1;
    wakeEvent <= 1'b1;
    @(posedge clk);
    writeStrobe <= 1'b0;
    wakeEvent <= 1'b0;
    rd(8'ha4, v);
    `CHK("setWins", 16'h8100, v)
    wr(8'ha4, 16'h8100);
    coldState <= 1'b0;
    $display("test cold done");
    // Mid-run reset restores every reset value
    @(posedge clk);
    reset <= 1'b1;
    wr(8'ha2, 16'h0000);
    @(posedge clk);
    reset <= 1'b0;
    rd(8'ha2, v);
    `CHK("capReset2", PMC_CAP_RESET, v)
    rd(8'ha4, v);
    `CHK("ctlReset2", 16'h0000, v)
    `CHK("reqReset2", 1'b0, wakeRequest_q)
    $display("test rereset done");
    results();
  end

endmodule : tb_top
